/* File: rtl/cbmx_pin_if.sv */
`timescale 1ns/1ns
interface cbmx_pin_if;
  logic [31:0]                   select;
  logic                          serialMode;
  logic                          romUsed;
  logic                          speakerHiz;
  logic [3:0]                    gpioDir;
  logic [cbmx_pkg::NUM_SRC-1:0]  sources;
  logic [cbmx_pkg::NUM_PINS-1:0] pinOut;
  logic [cbmx_pkg::NUM_PINS-1:0] pinOe;

  modport ctrl (output select, serialMode, romUsed, speakerHiz, gpioDir, sources,
                input pinOut, pinOe);
  modport mux  (input select, serialMode, romUsed, speakerHiz, gpioDir, sources,
                output pinOut, pinOe);
endinterface

/* File: rtl/cbmx_pin_mux.sv */
`timescale 1ns/1ns
module cbmx_pin_mux
(
  // selection and sources in, pin drive out
  cbmx_pin_if.mux pins
);

  // one selector per interrupt pin
  for (genvar i = 0; i < cbmx_pkg::NUM_PINS; i++)
  begin : g_pin
    logic [2:0] code;
    logic [4:0] src;

    always_comb
    begin
      code = pins.select[cbmx_pkg::PIN_TOP_LSB - i * cbmx_pkg::PIN_FIELD_W +: 3];
      // pins borrowed by the serial rom cannot be remapped
      if (pins.romUsed && (i == cbmx_pkg::PIN_IRQ12 || i == cbmx_pkg::PIN_IRQ11))
      begin
        code = cbmx_pkg::CODE_DEFAULT;
      end
      src = cbmx_pkg::PIN_MAP[i][code];
      // serial mode changes the default role; irq9 is pinned to the serial line
      if (pins.serialMode && (code == cbmx_pkg::CODE_DEFAULT || i == cbmx_pkg::PIN_IRQ9))
      begin
        src = cbmx_pkg::PIN_SERIAL_DEFAULT[i];
      end
      pins.pinOut[i] = 1'b0;
      pins.pinOe[i]  = 1'b0;
      if (src == cbmx_pkg::SRC_HIZ)
      begin
        pins.pinOe[i] = 1'b0;
      end
      else if (src == cbmx_pkg::SRC_SERIAL)
      begin
        // open drain: only pulls low
        pins.pinOe[i] = pins.sources[cbmx_pkg::SRC_SERIAL];
      end
      else if (src >= cbmx_pkg::SRC_GENERAL_PIN_0 && src <= cbmx_pkg::SRC_GENERAL_PIN_3)
      begin
        pins.pinOut[i] = pins.sources[src];
        pins.pinOe[i]  = pins.select[cbmx_pkg::C_GPIO_ENABLE]
                         & pins.gpioDir[2'(src - cbmx_pkg::SRC_GENERAL_PIN_0)];
      end
      else if (src == cbmx_pkg::SRC_SPK)
      begin
        pins.pinOut[i] = pins.sources[src];
        pins.pinOe[i]  = ~pins.speakerHiz;
      end
      else
      begin
        pins.pinOut[i] = pins.sources[src];
        pins.pinOe[i]  = 1'b1;
      end
    end
  end

endmodule

/* File: rtl/cbmx_pkg.sv */
package cbmx_pkg;

  // timing
  localparam int CLK_MHZ       = 250;
  localparam int RETRY_TIME_US = 2000;
  localparam int RETRY_CYCLES  = RETRY_TIME_US * CLK_MHZ;

  // configuration space byte offsets
  localparam logic [7:0] OFS_CTRL_A  = 8'hA0;
  localparam logic [7:0] OFS_CTRL_B  = 8'hA2;
  localparam logic [7:0] OFS_PIN_SEL = 8'hA4;

  // reset values
  localparam logic [15:0] RST_CTRL_A  = 16'h0000;
  localparam logic [15:0] RST_CTRL_B  = 16'h0000;
  localparam logic [31:0] RST_PIN_SEL = 32'h0000_0000;

  // socket_control_a fields
  localparam int A_WP_PULLUP_OFF  = 15;
  localparam int A_RESET_PULLUP   = 14;
  localparam int A_VIDEO_ENABLE   = 10;
  localparam int A_IO_MIN_TIMING  = 9;
  localparam int A_MEM_MIN_TIMING = 8;
  localparam int A_CSC_ISA_ONLY   = 7;
  localparam int A_CARD_IRQ_BLOCK = 6;
  localparam int A_CCLKRUN_PU_OFF = 5;
  localparam int A_STOPCLK_IGNORE = 4;
  localparam int A_WAKE_ENABLE    = 1;
  localparam int A_WAIT_STRETCH   = 0;

  // socket_control_b fields
  localparam int B_NOT_A_CARD     = 4;
  localparam int B_SPEAKER_HIZ    = 3;
  localparam int B_RETRY_FOREVER  = 2;
  localparam int B_CLKRUN_REFUSE  = 1;
  localparam int B_DUAL_REPORT    = 0;

  // interrupt_pin_function_select fields
  localparam int C_GPIO_ENABLE    = 31;
  localparam int PIN_TOP_LSB      = 27;
  localparam int PIN_FIELD_W      = 3;
  localparam int NUM_PINS         = 10;
  localparam int PIN_IRQ9         = 5;
  localparam int PIN_IRQ12        = 2;
  localparam int PIN_IRQ11        = 3;
  localparam logic [2:0] CODE_DEFAULT = 3'h0;
  localparam logic [2:0] CODE_HIZ     = 3'h5;

  // pin source indices: 0..15 are irq request lines
  localparam int SRC_W = 5;
  localparam int NUM_SRC = 25;
  localparam logic [4:0] SRC_SPK    = 5'h10;
  localparam logic [4:0] SRC_D3     = 5'h11;
  localparam logic [4:0] SRC_LAMP   = 5'h12;
  localparam logic [4:0] SRC_VIDEO  = 5'h13;
  localparam logic [4:0] SRC_GENERAL_PIN_0  = 5'h14;
  localparam logic [4:0] SRC_GENERAL_PIN_3  = 5'h17;
  localparam logic [4:0] SRC_SERIAL = 5'h18;
  localparam logic [4:0] SRC_HIZ    = 5'h1F;

  // per pin (irq15,14,12,11,10,9,7,5,4,3), per code 000..111
  localparam logic [4:0] PIN_MAP [NUM_PINS][8] = '{
    '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h05},
    '{5'h0E, 5'h10, 5'h12, 5'h13, 5'h04, 5'h1F, 5'h10, 5'h11},
    '{5'h0C, 5'h10, 5'h12, 5'h13, 5'h03, 5'h1F, 5'h10, 5'h11},
    '{5'h0B, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h0C},
    '{5'h0A, 5'h10, 5'h12, 5'h13, 5'h0C, 5'h0F, 5'h10, 5'h1F},
    '{5'h09, 5'h10, 5'h0C, 5'h13, 5'h12, 5'h0F, 5'h10, 5'h1F},
    '{5'h07, 5'h10, 5'h0E, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h17},
    '{5'h05, 5'h10, 5'h0C, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h16},
    '{5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h15},
    '{5'h03, 5'h10, 5'h0C, 5'h12, 5'h13, 5'h1F, 5'h10, 5'h14}
  };

  // code 000 in serial interrupt mode
  localparam logic [4:0] PIN_SERIAL_DEFAULT [NUM_PINS] = '{
    5'h13, 5'h0E, 5'h0C, 5'h0B, 5'h12, 5'h18, 5'h17, 5'h16, 5'h15, 5'h14
  };

  // synchroniser vector layout
  localparam int SYN_CSTSCHG = 0;
  localparam int SYN_WAIT_N  = 1;
  localparam int SYN_SUSPEND = 2;
  localparam int SYN_DETECT  = 3;
  localparam int SYN_VSENSE  = 5;
  localparam int SYN_GPIO    = 7;
  localparam int SYN_W       = 11;

endpackage

/* File: rtl/cbmx_socket_misc.sv */
`timescale 1ns/1ns
module cbmx_socket_misc
#(
  parameter int RETRY_CYCLES = cbmx_pkg::RETRY_CYCLES
)
(
  // clock and global reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // configuration access
  input  wire logic        cfgStrobe,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output logic      [31:0] cfgRdata,
  output logic             cfgAck,
  // socket pins
  input  wire logic        cstschgPin,
  input  wire logic        cardWaitN,
  input  wire logic        hwSuspendPin,
  input  wire logic [1:0]  cardDetectN,
  input  wire logic [1:0]  voltSensePin,
  input  wire logic [3:0]  gpioPinIn,
  // socket state from bridge logic
  input  wire logic        cardIs16Bit,
  input  wire logic        cardPresent,
  input  wire logic        cardSupports3v,
  input  wire logic        cardSupports5v,
  input  wire logic        excaVideoEnable,
  input  wire logic        statusChange,
  input  wire logic        cardIrq,
  input  wire logic        isaIrqEnable,
  input  wire logic        stopClockReq,
  input  wire logic        hostClkrunReq,
  input  wire logic        retryPending,
  // pin function sources
  input  wire logic [15:0] irqRequest,
  input  wire logic        speaker_audio_out,
  input  wire logic        power_d3_flag_out,
  input  wire logic        card_activity_lamp,
  input  wire logic        serialIrqDrive,
  input  wire logic [3:0]  gpioDir,
  input  wire logic [3:0]  gpioData,
  input  wire logic        serialMode,
  input  wire logic        serialRomUsed,
  // socket controls out
  output logic             wpPullupEn,
  output logic             resetPullupEn,
  output logic             cclkrunPullupEn,
  output logic             video_port_enable_out,
  output logic             ioMinTiming,
  output logic             memMinTiming,
  output logic             cscToPciInt,
  output logic             cscToIsa,
  output logic             cardIrqToIsa,
  output logic             stopClockEffective,
  output logic             wakeInput,
  output logic             waitStretched,
  output logic             notACard,
  output logic             card5v16Bit,
  output logic             retryAbort,
  output logic             clkrunGrant,
  output logic             present3v,
  output logic             present5v,
  // interrupt pins
  output logic [9:0]       pinOut,
  output logic [9:0]       pinOe,
  output logic [3:0]       gpioIn
);

  localparam int CNT_W = $clog2(RETRY_CYCLES + 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);

  if (RETRY_CYCLES < 2)
  begin : g_check
    $error("RETRY_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [15:0]                  ctrlA;
    logic [15:0]                  ctrlB;
    logic [31:0]                  pinSel;
    logic [31:0]                  rdata;
    logic                         ack;
    logic [cbmx_pkg::SYN_W-1:0]   syncA;
    logic [cbmx_pkg::SYN_W-1:0]   syncB;
    logic                         waitPrev;
    logic [CNT_W-1:0]             retryCount;
    logic                         wpPu;
    logic                         resetPu;
    logic                         cclkPu;
    logic                         video;
    logic                         ioMin;
    logic                         memMin;
    logic                         cscPci;
    logic                         cscIsa;
    logic                         cintIsa;
    logic                         stopClk;
    logic                         wake;
    logic                         waitOut;
    logic                         nac;
    logic                         c5v16;
    logic                         abort;
    logic                         grant;
    logic                         p3v;
    logic                         p5v;
    logic [9:0]                   pOut;
    logic [9:0]                   pOe;
    logic [3:0]                   gpio;
  } cbmx_state_type;

  cbmx_state_type st;
  cbmx_state_type next_st;
  cbmx_pin_if     pinBus ();

  logic           waitActive;
  logic [31:0]    wordA;
  logic [31:0]    mergedA;
  logic [31:0]    mergedC;

  // pin multiplexer sources
  assign pinBus.select     = st.pinSel;
  assign pinBus.serialMode = serialMode;
  assign pinBus.romUsed    = serialRomUsed;
  assign pinBus.speakerHiz = st.ctrlB[cbmx_pkg::B_SPEAKER_HIZ]
                             & st.syncB[cbmx_pkg::SYN_SUSPEND];
  assign pinBus.gpioDir    = gpioDir;
  assign pinBus.sources    = {serialIrqDrive, gpioData, video_port_enable_out,
                              card_activity_lamp, power_d3_flag_out, speaker_audio_out,
                              irqRequest};

  cbmx_pin_mux u_mux
  (
    .pins (pinBus.mux)
  );

  // byte-lane merge of a write into the addressed dword
  assign wordA = {st.ctrlB, st.ctrlA};
  always_comb
  begin
    mergedA = wordA;
    mergedC = st.pinSel;
    for (int b = 0; b < 4; b++)
    begin
      if (cfgByteEn[b])
      begin
        mergedA[b*8 +: 8] = cfgWdata[b*8 +: 8];
        mergedC[b*8 +: 8] = cfgWdata[b*8 +: 8];
      end
    end
  end

  assign waitActive = ~st.syncB[cbmx_pkg::SYN_WAIT_N];

  // next state
  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    // pins pass two flops; only stage two is read below
    next_st.syncA = {gpioPinIn, voltSensePin, cardDetectN, hwSuspendPin, cardWaitN,
                     cstschgPin};
    next_st.syncB = st.syncA;

    // register access; reserved bits simply store
    if (cfgStrobe)
    begin
      next_st.ack = 1'b1;
      if (cfgWrite)
      begin
        if (cfgAddr[7:2] == cbmx_pkg::OFS_CTRL_A[7:2])
        begin
          next_st.ctrlA = mergedA[15:0];
          next_st.ctrlB = mergedA[31:16];
        end
        if (cfgAddr[7:2] == cbmx_pkg::OFS_PIN_SEL[7:2])
        begin
          next_st.pinSel = mergedC;
        end
      end
      else if (cfgAddr[7:2] == cbmx_pkg::OFS_CTRL_A[7:2])
      begin
        next_st.rdata = wordA;
      end
      else if (cfgAddr[7:2] == cbmx_pkg::OFS_PIN_SEL[7:2])
      begin
        next_st.rdata = st.pinSel;
      end
      else
      begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // pullups and timing overrides
    next_st.wpPu    = cardIs16Bit & ~st.ctrlA[cbmx_pkg::A_WP_PULLUP_OFF];
    next_st.resetPu = st.ctrlA[cbmx_pkg::A_RESET_PULLUP];
    next_st.cclkPu  = ~st.ctrlA[cbmx_pkg::A_CCLKRUN_PU_OFF];
    next_st.video   = st.ctrlA[cbmx_pkg::A_VIDEO_ENABLE] | excaVideoEnable;
    next_st.ioMin   = st.ctrlA[cbmx_pkg::A_IO_MIN_TIMING];
    next_st.memMin  = st.ctrlA[cbmx_pkg::A_MEM_MIN_TIMING];

    // interrupt routing
    next_st.cscPci  = statusChange & ~st.ctrlA[cbmx_pkg::A_CSC_ISA_ONLY];
    next_st.cscIsa  = statusChange & st.ctrlA[cbmx_pkg::A_CSC_ISA_ONLY];
    next_st.cintIsa = cardIrq & isaIrqEnable & ~st.ctrlA[cbmx_pkg::A_CARD_IRQ_BLOCK];

    // clock controls
    next_st.stopClk = stopClockReq & ~st.ctrlA[cbmx_pkg::A_STOPCLK_IGNORE];
    next_st.grant   = hostClkrunReq & ~st.ctrlB[cbmx_pkg::B_CLKRUN_REFUSE];

    // wake input is dead without a card, whatever the bit says
    next_st.wake = st.syncB[cbmx_pkg::SYN_CSTSCHG] & cardPresent
                   & st.ctrlA[cbmx_pkg::A_WAKE_ENABLE];

    // wait held one clock past release to widen the command pulse
    next_st.waitPrev = waitActive;
    next_st.waitOut  = waitActive
                       | (st.waitPrev & st.ctrlA[cbmx_pkg::A_WAIT_STRETCH]);

    // grounded detect with open sense pins
    next_st.nac   = 1'b0;
    next_st.c5v16 = 1'b0;
    if (st.syncB[cbmx_pkg::SYN_DETECT +: 2] == 2'h0
        && st.syncB[cbmx_pkg::SYN_VSENSE +: 2] == 2'h3)
    begin
      next_st.nac   = st.ctrlB[cbmx_pkg::B_NOT_A_CARD];
      next_st.c5v16 = ~st.ctrlB[cbmx_pkg::B_NOT_A_CARD];
    end

    // voltage report bits
    next_st.p3v = cardSupports3v;
    next_st.p5v = st.ctrlB[cbmx_pkg::B_DUAL_REPORT] ? (cardSupports3v | cardSupports5v)
                                                     : (cardSupports5v & ~cardSupports3v);

    // delayed transaction retry watchdog
    next_st.abort = 1'b0;
    if (!retryPending || st.ctrlB[cbmx_pkg::B_RETRY_FOREVER])
    begin
      next_st.retryCount = '0;
    end
    else if (st.retryCount == RETRY_LAST)
    begin
      next_st.retryCount = '0;
      next_st.abort      = 1'b1;
    end
    else
    begin
      next_st.retryCount = st.retryCount + CNT_W'(1);
    end

    // pin drive registered so the pads see clean levels
    next_st.pOut = pinBus.pinOut;
    next_st.pOe  = pinBus.pinOe;
    // gpio inputs read as zero while the pins serve irq functions
    next_st.gpio = st.pinSel[cbmx_pkg::C_GPIO_ENABLE] ? st.syncB[cbmx_pkg::SYN_GPIO +: 4]
                                                       : 4'h0;
  end

  // state register; rstn is the global reset and the only clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st        <= '0;
      st.ctrlA  <= cbmx_pkg::RST_CTRL_A;
      st.ctrlB  <= cbmx_pkg::RST_CTRL_B;
      st.pinSel <= cbmx_pkg::RST_PIN_SEL;
      st.syncA  <= {cbmx_pkg::SYN_W{1'b1}};
      st.syncB  <= {cbmx_pkg::SYN_W{1'b1}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs
  assign cfgRdata              = st.rdata;
  assign cfgAck                = st.ack;
  assign wpPullupEn            = st.wpPu;
  assign resetPullupEn         = st.resetPu;
  assign cclkrunPullupEn       = st.cclkPu;
  assign video_port_enable_out = st.video;
  assign ioMinTiming           = st.ioMin;
  assign memMinTiming          = st.memMin;
  assign cscToPciInt           = st.cscPci;
  assign cscToIsa              = st.cscIsa;
  assign cardIrqToIsa          = st.cintIsa;
  assign stopClockEffective    = st.stopClk;
  assign wakeInput             = st.wake;
  assign waitStretched         = st.waitOut;
  assign notACard              = st.nac;
  assign card5v16Bit           = st.c5v16;
  assign retryAbort            = st.abort;
  assign clkrunGrant           = st.grant;
  assign present3v             = st.p3v;
  assign present5v             = st.p5v;
  assign pinOut                = st.pOut;
  assign pinOe                 = st.pOe;
  assign gpioIn                = st.gpio;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wait_drop;
    st.ctrlA[cbmx_pkg::A_WAIT_STRETCH] && $fell(waitActive) ##1 !waitActive;
  endsequence

  sequence s_retry_idle;
    !retryPending || st.ctrlB[cbmx_pkg::B_RETRY_FOREVER];
  endsequence

  a_reset_clear: assert property ($rose(rstn) |-> st.ctrlA == '0 && st.pinSel == '0)
    else $error("control registers not clear after reset");
  a_wp_pullup: assert property (st.ctrlA[cbmx_pkg::A_WP_PULLUP_OFF] ##1
                                st.ctrlA[cbmx_pkg::A_WP_PULLUP_OFF] |-> !wpPullupEn)
    else $error("wp pullup on while disabled");
  a_video_or: assert property ((excaVideoEnable || st.ctrlA[cbmx_pkg::A_VIDEO_ENABLE])
                               |=> video_port_enable_out)
    else $error("video port not enabled");
  a_min_timing: assert property (st.ctrlA[cbmx_pkg::A_IO_MIN_TIMING] |=> ioMinTiming)
    else $error("io minimum timing not forced");
  a_csc_route: assert property (statusChange && st.ctrlA[cbmx_pkg::A_CSC_ISA_ONLY]
                                |=> !cscToPciInt && cscToIsa)
    else $error("status change misrouted");
  a_cint_block: assert property (st.ctrlA[cbmx_pkg::A_CARD_IRQ_BLOCK] |=> !cardIrqToIsa)
    else $error("card interrupt reached isa");
  a_wake_gate: assert property (!cardPresent |=> !wakeInput)
    else $error("wake input live without card");
  a_wait_stretch: assert property (s_wait_drop |-> waitStretched ##1 !waitStretched)
    else $error("wait not stretched by one clock");
  a_retry_abort: assert property (retryAbort |-> $past(st.retryCount) == RETRY_LAST
                                  && $past(retryPending))
    else $error("retry abort at wrong count");
  a_retry_forever: assert property (s_retry_idle |=> !retryAbort)
    else $error("retry abandoned while disabled");
  a_clkrun_refuse: assert property (st.ctrlB[cbmx_pkg::B_CLKRUN_REFUSE] |=> !clkrunGrant)
    else $error("clock run granted while refused");
  a_irq15_hiz: assert property (st.pinSel[cbmx_pkg::PIN_TOP_LSB +: 3] == cbmx_pkg::CODE_HIZ
                                |=> !pinOe[0])
    else $error("irq15 pin driven in hi-z code");

endmodule

/* File: tb/cbmx_socket_model.sv */
`timescale 1ns/1ns
module cbmx_socket_model
(
  // scenario control
  input  wire logic [1:0] cardKind,
  input  wire logic       wakeReq,
  // socket side
  output logic            cstschgPin,
  output logic [1:0]      cardDetectN,
  output logic [1:0]      voltSensePin,
  output logic            cardPresent,
  output logic            cardSupports3v,
  output logic            cardSupports5v,
  output logic            cclkrunLine
);
  // kind 0 empty, 1 grounded detect with open sense, 2 a 3v card, 3 a dual card
  always_comb
  begin
    cardPresent    = cardKind != 2'h0;
    cardDetectN    = cardPresent ? 2'h0 : 2'h3;
    voltSensePin   = (cardKind == 2'h1) ? 2'h3 : 2'h0;
    cardSupports3v = cardKind[1];
    cardSupports5v = cardKind == 2'h3;
    cstschgPin     = wakeReq; // driven even when empty, so gating is visible
  end
  // board pull-up holds the line once the internal one is switched off
  assign cclkrunLine = 1'h1;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  localparam int RETRY_P = 16;
  // clock, reset and configuration port
  logic        clk_sys = 1'h0;
  logic        rstn = 1'h0;
  logic        cfgStrobe = 1'h0;
  logic        cfgWrite = 1'h0;
  logic [7:0]  cfgAddr = 8'h00;
  logic [3:0]  cfgByteEn = 4'hF;
  logic [31:0] cfgWdata = 32'h0000_0000;
  logic [31:0] cfgRdata, rd;
  logic        cfgAck;
  // levels driven here
  logic        cardWaitN = 1'h1, hwSuspendPin = 1'h0, lv = 1'h1, retryPending = 1'h0;
  logic        speaker_audio_out = 1'h1, serialIrqDrive = 1'h0, serialMode = 1'h0;
  logic        serialRomUsed = 1'h0, wakeReq = 1'h0, a;
  logic [1:0]  cardKind = 2'h3;
  logic [3:0]  gpioPinIn = 4'h5, gpioDir = 4'h0, gpioData = 4'hA;
  logic [15:0] irqRequest = 16'hFFFF;
  logic [2:0]  cd;
  logic [9:0]  oeX;
  // partner and design outputs
  logic        cstschgPin, cardPresent, cardSupports3v, cardSupports5v, cclkrunLine;
  logic [1:0]  cardDetectN, voltSensePin;
  logic        wpPullupEn, resetPullupEn, cclkrunPullupEn, video_port_enable_out;
  logic        ioMinTiming, memMinTiming, cscToPciInt, cscToIsa, cardIrqToIsa;
  logic        stopClockEffective, wakeInput, waitStretched, notACard, card5v16Bit;
  logic        retryAbort, clkrunGrant, present3v, present5v;
  logic [9:0]  pinOut, pinOe;
  logic [3:0]  gpioIn;
  int          mismatches = 0, compares = 0, n, lenW[2];
  // output groups checked together; offV and onV each share one expectation
  wire  [4:0]  offV = {wpPullupEn, cscToPciInt, cardIrqToIsa, stopClockEffective, clkrunGrant};
  wire  [3:0]  onV = {resetPullupEn, ioMinTiming, memMinTiming, present5v};
  wire  [3:0]  miscV = {cclkrunPullupEn, video_port_enable_out, cscToIsa, present3v};

  cbmx_socket_model partner
  (
    .cardKind, .wakeReq, .cstschgPin, .cardDetectN, .voltSensePin, .cardPresent,
    .cardSupports3v, .cardSupports5v, .cclkrunLine
  );

  cbmx_socket_misc #(.RETRY_CYCLES(RETRY_P)) uut
  (
    .clk_sys, .rstn, .cfgStrobe, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata, .cfgRdata,
    .cfgAck, .cstschgPin, .cardWaitN, .hwSuspendPin, .cardDetectN, .voltSensePin, .gpioPinIn,
    .cardIs16Bit(lv), .cardPresent, .cardSupports3v, .cardSupports5v, .excaVideoEnable(lv),
    .statusChange(lv), .cardIrq(lv), .isaIrqEnable(lv), .stopClockReq(lv), .hostClkrunReq(lv),
    .retryPending, .irqRequest, .speaker_audio_out, .power_d3_flag_out(speaker_audio_out),
    .card_activity_lamp(speaker_audio_out), .serialIrqDrive, .gpioDir, .gpioData, .serialMode,
    .serialRomUsed, .wpPullupEn, .resetPullupEn, .cclkrunPullupEn, .video_port_enable_out,
    .ioMinTiming, .memMinTiming, .cscToPciInt, .cscToIsa, .cardIrqToIsa, .stopClockEffective,
    .wakeInput, .waitStretched, .notACard, .card5v16Bit, .retryAbort, .clkrunGrant,
    .present3v, .present5v, .pinOut, .pinOe, .gpioIn
  );

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // one access; strobe is a single-cycle pulse, ack awaited under a bound
  task automatic cfg(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    t = 0;
    @(negedge clk_sys);
    cfgStrobe = 1'h1;
    cfgWrite = wr;
    cfgAddr = ad;
    cfgWdata = wd;
    @(negedge clk_sys);
    cfgStrobe = 1'h0;
    while (cfgAck !== 1'h1 && t < 4)
    begin
      @(negedge clk_sys);
      t++;
    end
    if (cfgAck !== 1'h1)
    begin
      mismatches++;
      print_verdict();
    end
    rd = cfgRdata;
  endtask

  // hang guard
  initial
  begin
    tick(20000);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    tick(8);
    rstn = 1'h1;
    tick(2);
    cfg(0, 8'hA0, 0);
    chk("ctrlAB", 0, rd);
    // control bits all clear or all set, with both socket levels; reserved b bits kept zero
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 1 || k == 2);
      lv = (k < 2);
      cfg(1, 8'hA0, a ? 32'h001F_FFFF : 32'h0);
      cfg(0, 8'hA0, 0);
      chk("ctrlAB", a ? 32'h001F_FFFF : 32'h0, rd);
      tick(3);
      chk("offV", {5{lv & ~a}}, offV);
      chk("onV", {4{a}}, onV);
      chk("miscV", {~a, a | lv, lv & a, 1'h1}, miscV);
    end
    lv = 1'h1;
    // wake gating and grounded-detect decode
    wakeReq = 1'h1;
    cardKind = 2'h1;
    cfg(1, 8'hA0, 32'h0010_0002);
    tick(5);
    chk("wake", 1, wakeInput);
    chk("decode", 2'h2, {notACard, card5v16Bit});
    cfg(1, 8'hA0, 32'h0000_0002);
    tick(5);
    chk("decode", 2'h1, {notACard, card5v16Bit});
    cardKind = 2'h0;
    tick(5);
    chk("wake", 0, wakeInput);
    cardKind = 2'h3;
    cfg(1, 8'hA0, 0);
    tick(5);
    chk("wake", 0, wakeInput);
    // tail of the wait after release, without and with stretch
    for (int s = 0; s < 2; s++)
    begin
      cfg(1, 8'hA0, s);
      cardWaitN = 1'h0;
      tick(6);
      cardWaitN = 1'h1;
      lenW[s] = 0;
      repeat (12)
      begin
        @(negedge clk_sys);
        lenW[s] += waitStretched;
      end
    end
    chk("stretch", 1, lenW[1] - lenW[0]);
    // abandoned retry repeats every count unless endless retry is set
    cfg(1, 8'hA0, 0);
    retryPending = 1'h1;
    n = 0;
    while (retryAbort !== 1'h1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("firstAbort", 1, n <= RETRY_P + 3);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (retryAbort !== 1'h1 && n < 40);
    chk("abortGap", 1, n >= RETRY_P && n <= RETRY_P + 1);
    cfg(1, 8'hA0, 32'h0004_0000);
    n = 0;
    repeat (40)
    begin
      @(negedge clk_sys);
      n += retryAbort;
    end
    chk("noAbort", 0, n);
    retryPending = 1'h0;
    // all codes on all pins; suspend raised with the second speaker code
    cfg(1, 8'hA0, 32'h0008_0000);
    for (int c = 0; c < 8; c++)
    begin
      cd = c[2:0];
      hwSuspendPin = (cd == 3'h6);
      cfg(1, 8'hA4, {2'h0, {10{cd}}});
      tick(5);
      oeX = (cd == 3'h5) ? 10'h030 : (cd == 3'h7) ? 10'h00F : (cd == 3'h6) ? 10'h000 : 10'h3FF;
      chk("pinOe", oeX, pinOe);
      if (cd == 3'h1)
        chk("pinOut", 10'h3FF, pinOut);
    end
    hwSuspendPin = 1'h0;
    gpioDir = 4'hF;
    cfg(1, 8'hA4, 32'h8000_0FFF);
    tick(5);
    chk("gpio", 12'hF55, {pinOe[9:6], pinOut[9:6], gpioIn});
    cfg(1, 8'hA4, 32'h0000_0FFF);
    tick(5);
    chk("gpioOff", 0, {pinOe[9:6], gpioIn});
    serialMode = 1'h1;
    serialRomUsed = 1'h1;
    serialIrqDrive = 1'h1;
    cfg(1, 8'hA4, 32'h00A0_3000);
    tick(5);
    chk("serial", 3'h5, {pinOe[5], pinOut[5], pinOe[2]});
    cfg(0, 8'hA4, 0);
    chk("pinSel", 32'h00A0_3000, rd);
    cfg(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    // reset in mid-run clears everything written
    cfg(1, 8'hA0, 32'h001F_FFFF);
    // lower lanes only: control b must keep its bits
    cfgByteEn = 4'h3;
    cfg(1, 8'hA0, 32'h0000_0000);
    cfgByteEn = 4'hF;
    cfg(0, 8'hA0, 0);
    chk("laneMask", 32'h001F_0000, rd);
    rstn = 1'h0;
    tick(2);
    rstn = 1'h1;
    tick(2);
    cfg(0, 8'hA0, 0);
    chk("ctrlAB", 0, rd);
    cfg(0, 8'hA4, 0);
    chk("pinSel", 0, rd);
    print_verdict();
  end
endmodule
